// >>> hdl/lat_pkg.sv
// constants and types for the lifecycle / authentication-level transition sequencer
// ==========================================================================
package lat_pkg;
   localparam logic [7:0] LAT_REPLY_OK = 8'h30;
   localparam logic [7:0] LAT_REPLY_ERR = 8'hb0;
   localparam logic [31:0] LAT_UNUSED = 32'hffffffff;
   // status codes
   localparam logic [7:0] LAT_STAT_OK = 8'h00;
   localparam logic [7:0] LAT_STAT_PACKET = 8'hc1;
   localparam logic [7:0] LAT_STAT_CHECKSUM = 8'hc2;
   localparam logic [7:0] LAT_STAT_ACCEPT = 8'hc3;
   localparam logic [7:0] LAT_STAT_MISMATCH = 8'hc4;
   localparam logic [7:0] LAT_STAT_PARAM = 8'hc5;
   localparam logic [7:0] LAT_STAT_PROTECT = 8'hc6;
   localparam logic [7:0] LAT_STAT_TRUSTED = 8'hc7;
   localparam logic [7:0] LAT_STAT_FLASH = 8'hc8;
   localparam logic [7:0] LAT_STAT_HARDWARE = 8'hc9;
   // lifecycle state and authentication level codes
   localparam logic [7:0] LAT_LC_DEV = 8'h01;
   localparam logic [7:0] LAT_LC_MANUF = 8'h02;
   localparam logic [7:0] LAT_LC_SECURE = 8'h03;
   localparam logic [7:0] LAT_LC_RTV_REQ = 8'h04;
   localparam logic [7:0] LAT_AL_ZERO = 8'h10;
   localparam logic [7:0] LAT_AL_ONE = 8'h11;
   localparam logic [7:0] LAT_AL_TWO = 8'h12;
   // challenge types
   localparam logic [7:0] LAT_CHAL_RANDOM = 8'h00;
   localparam logic [7:0] LAT_CHAL_UID = 8'h01;
   // erase regions in erase order
   localparam logic [2:0] LAT_RGN_PROTECT = 3'h0;
   localparam logic [2:0] LAT_RGN_USER = 3'h1;
   localparam logic [2:0] LAT_RGN_DATA = 3'h2;
   localparam logic [2:0] LAT_RGN_CONFIG = 3'h3;
   localparam logic [2:0] LAT_RGN_NVCFG = 3'h4;
   localparam logic [2:0] LAT_RGN_KEYIDX = 3'h5;
   localparam logic [2:0] LAT_RGN_LAST = LAT_RGN_KEYIDX;
   typedef enum logic [2:0] {
      LAT_ST_IDLE = 3'b000,
      LAT_ST_WAIT_RESP = 3'b001,
      LAT_ST_AUTH = 3'b010,
      LAT_ST_ERASE = 3'b011,
      LAT_ST_COMMIT = 3'b100,
      LAT_ST_CHECK = 3'b101,
      LAT_ST_DEAD = 3'b110
   } lat_state_type;
   typedef struct packed {
      logic [7:0] src;
      logic [7:0] dst;
      logic [7:0] chal_type;
   } lat_cmd_type;
   typedef struct packed {
      logic [7:0] reply;
      logic [255:0] mac;
   } lat_resp_type;
   typedef struct packed {
      logic [7:0] reply;
      logic [7:0] code;
      logic [31:0] detail;
      logic [31:0] adr;
   } lat_status_type;
   typedef struct packed {
      logic [2:0] region;
      logic force_erase;
      logic spare_perm;
      logic keep_locked_units;
   } lat_erase_type;
endpackage

// >>> hdl/lat_transition.sv
// lifecycle / authentication-level transition sequencer, late phases
`timescale 1ns/10ps
module lat_transition
(
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic SRST,
   // command and device state
   input wire logic CMD_START,
   input wire lat_pkg::lat_cmd_type CMD,
   input wire logic [7:0] CUR_LIFECYCLE,
   input wire logic [7:0] CUR_AUTH_LEVEL,
   input wire logic PROT_LVL_BAD,
   input wire logic LVL1_KEY_EN,
   input wire logic LVL2_KEY_EN,
   // received response packet
   input wire logic RESP_VALID,
   input wire lat_pkg::lat_resp_type RESP,
   // security subsystem
   input wire logic TRUST_ABNORMAL,
   input wire logic CMAC_DONE,
   input wire logic CMAC_FAIL,
   input wire logic [127:0] CMAC_VALUE,
   output logic CMAC_REQ,
   output logic CMAC_KEY_LVL2,
   // flash controller
   output logic ERASE_REQ,
   output lat_pkg::lat_erase_type ERASE_MODE,
   input wire logic FL_DONE,
   input wire logic FL_ERR,
   input wire logic [31:0] FL_STATUS,
   input wire logic [31:0] FL_ADDR,
   input wire logic FL_DISCLOSED,
   // state commit
   output logic COMMIT_REQ,
   output logic [7:0] COMMIT_DST,
   input wire logic COMMIT_DONE,
   input wire logic COMMIT_ERR,
   input wire logic COMMIT_ERR_TRUST,
   // status reply
   output logic STATUS_VALID,
   output lat_pkg::lat_status_type STATUS,
   output logic BUSY,
   output logic UNRESPONSIVE
);
   import lat_pkg::*;

   // ==========================================================================
   // helpers
   function automatic logic is_al(input logic [7:0] c);
      return (c == LAT_AL_ZERO) || (c == LAT_AL_ONE) || (c == LAT_AL_TWO);
   endfunction

   function automatic logic lc_valid(input logic [7:0] c);
      return (c == LAT_LC_DEV) || (c == LAT_LC_MANUF) || (c == LAT_LC_SECURE) || (c == LAT_LC_RTV_REQ);
   endfunction

   function automatic lat_status_type mk_err(input logic [7:0] code);
      return '{reply: LAT_REPLY_ERR, code: code, detail: LAT_UNUSED, adr: LAT_UNUSED};
   endfunction

   function automatic lat_status_type mk_flash();
      return '{reply: LAT_REPLY_ERR, code: LAT_STAT_FLASH, detail: FL_STATUS,
               adr: FL_DISCLOSED ? FL_ADDR : LAT_UNUSED};
   endfunction

   // parameter checks, in descending priority
   function automatic logic [7:0] check_cmd(input lat_cmd_type c, input logic [7:0] lc, input logic [7:0] al,
                                            input logic k1, input logic k2, input logic bad);
      logic legal;
      legal = 1'b0;
      if (is_al(c.dst))
      begin
         legal = (lc == LAT_LC_MANUF) &&
                 (((c.src == LAT_AL_ZERO) && ((c.dst == LAT_AL_ONE) || (c.dst == LAT_AL_TWO))) ||
                  ((c.src == LAT_AL_ONE) && (c.dst == LAT_AL_TWO)));
      end
      else
      begin
         legal = lc_valid(c.dst) && (c.dst != c.src);
      end
      if ((c.src != lc) && (c.src != al))
         return LAT_STAT_PARAM;
      if (!legal)
         return LAT_STAT_PARAM;
      if (((c.dst == LAT_AL_TWO) || (c.dst == LAT_LC_RTV_REQ)) && !k2)
         return LAT_STAT_PROTECT;
      if ((c.dst == LAT_AL_ONE) && !k1)
         return LAT_STAT_PROTECT;
      if (!((c.chal_type == LAT_CHAL_RANDOM) || ((c.chal_type == LAT_CHAL_UID) && (c.dst == LAT_LC_RTV_REQ))))
         return LAT_STAT_PARAM;
      if (bad || !lc_valid(lc))
         return LAT_STAT_HARDWARE;
      return LAT_STAT_OK;
   endfunction

   function automatic lat_erase_type mk_erase(input logic [2:0] r);
      return '{region: r, force_erase: 1'b1,
               spare_perm: (r == LAT_RGN_USER) || (r == LAT_RGN_CONFIG),
               keep_locked_units: (r == LAT_RGN_NVCFG)};
   endfunction

   // ==========================================================================
   // state
   lat_state_type state_reg, state_next;
   lat_cmd_type cmd_reg;
   logic [2:0] region_reg, region_next;
   lat_status_type status_reg, status_next;
   logic send_reg, send_next;
   logic cmac_go, erase_go, commit_go;
   logic [7:0] chk_code;
   // response value sits in the first 16 bytes of the mac field
   logic [127:0] resp_mac_hi;
   logic [127:0] mac_reg;

   assign resp_mac_hi = mac_reg;

   assign chk_code = check_cmd(CMD, CUR_LIFECYCLE, CUR_AUTH_LEVEL, LVL1_KEY_EN, LVL2_KEY_EN, PROT_LVL_BAD);

   // ==========================================================================
   // sequencer
   always_comb
   begin
      state_next = state_reg;
      region_next = region_reg;
      status_next = status_reg;
      send_next = 1'b0;
      cmac_go = 1'b0;
      erase_go = 1'b0;
      commit_go = 1'b0;
      case (state_reg)
         LAT_ST_IDLE:
            if (CMD_START)
            begin
               if (chk_code != LAT_STAT_OK)
               begin
                  status_next = mk_err(chk_code);
                  send_next = 1'b1;
               end
               else
                  state_next = LAT_ST_WAIT_RESP;
            end
         LAT_ST_WAIT_RESP:
            if (RESP_VALID)
            begin
               if (RESP.reply != LAT_REPLY_OK)
               begin
                  status_next = mk_err(LAT_STAT_PACKET);
                  send_next = 1'b1;
                  state_next = LAT_ST_IDLE;
               end
               else
               begin
                  cmac_go = 1'b1;
                  state_next = LAT_ST_AUTH;
               end
            end
         LAT_ST_AUTH:
            if (CMAC_DONE)
            begin
               if (CMAC_FAIL || (CMAC_VALUE != resp_mac_hi))
               begin
                  status_next = mk_err(LAT_STAT_TRUSTED);
                  send_next = 1'b1;
                  state_next = LAT_ST_IDLE;
               end
               else if (TRUST_ABNORMAL)
                  state_next = LAT_ST_DEAD;
               else if (cmd_reg.dst == LAT_LC_RTV_REQ)
               begin
                  region_next = LAT_RGN_PROTECT;
                  erase_go = 1'b1;
                  state_next = LAT_ST_ERASE;
               end
               else
               begin
                  commit_go = 1'b1;
                  state_next = LAT_ST_COMMIT;
               end
            end
         LAT_ST_ERASE:
            if (TRUST_ABNORMAL)
               state_next = LAT_ST_DEAD;
            else if (FL_DONE)
            begin
               if (FL_ERR)
               begin
                  status_next = mk_flash();
                  send_next = 1'b1;
                  state_next = LAT_ST_IDLE;
               end
               else if (region_reg == LAT_RGN_LAST)
               begin
                  commit_go = 1'b1;
                  state_next = LAT_ST_COMMIT;
               end
               else
               begin
                  region_next = region_reg + 3'h1;
                  erase_go = 1'b1;
               end
            end
         LAT_ST_COMMIT:
            if (TRUST_ABNORMAL)
               state_next = LAT_ST_DEAD;
            else if (COMMIT_DONE)
            begin
               if (COMMIT_ERR)
               begin
                  status_next = COMMIT_ERR_TRUST ? mk_err(LAT_STAT_TRUSTED) : mk_flash();
                  send_next = 1'b1;
                  state_next = LAT_ST_IDLE;
               end
               else
                  state_next = LAT_ST_CHECK;
            end
         LAT_ST_CHECK:
         begin
            send_next = 1'b1;
            if (!lc_valid(CUR_LIFECYCLE) || PROT_LVL_BAD)
            begin
               status_next = mk_err(LAT_STAT_HARDWARE);
               state_next = LAT_ST_DEAD;
            end
            else
            begin
               status_next = '{reply: LAT_REPLY_OK, code: LAT_STAT_OK, detail: LAT_UNUSED, adr: LAT_UNUSED};
               state_next = is_al(cmd_reg.dst) ? LAT_ST_IDLE : LAT_ST_DEAD;
            end
         end
         LAT_ST_DEAD:
            state_next = LAT_ST_DEAD;
         default:
            state_next = LAT_ST_IDLE;
      endcase
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         state_reg <= LAT_ST_IDLE;
         region_reg <= LAT_RGN_PROTECT;
      end
      else
      begin
         state_reg <= state_next;
         region_reg <= region_next;
      end
   end

   // ==========================================================================
   // captured command and response
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         cmd_reg <= '0;
         mac_reg <= '0;
      end
      else
      begin
         if ((state_reg == LAT_ST_IDLE) && CMD_START)
            cmd_reg <= CMD;
         if ((state_reg == LAT_ST_WAIT_RESP) && RESP_VALID)
            mac_reg <= RESP.mac[255:128];
      end
   end

   // ==========================================================================
   // requests to security subsystem, flash and commit
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         CMAC_REQ <= 1'b0;
         CMAC_KEY_LVL2 <= 1'b0;
         ERASE_REQ <= 1'b0;
         ERASE_MODE <= '0;
         COMMIT_REQ <= 1'b0;
         COMMIT_DST <= '0;
      end
      else
      begin
         CMAC_REQ <= cmac_go;
         if (cmac_go)
            CMAC_KEY_LVL2 <= (cmd_reg.dst != LAT_AL_ONE);
         ERASE_REQ <= erase_go;
         if (erase_go)
            ERASE_MODE <= mk_erase(region_next);
         COMMIT_REQ <= commit_go;
         if (commit_go)
            COMMIT_DST <= cmd_reg.dst;
      end
   end

   // ==========================================================================
   // status reply
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         status_reg <= '{reply: LAT_REPLY_OK, code: LAT_STAT_OK, detail: LAT_UNUSED, adr: LAT_UNUSED};
         send_reg <= 1'b0;
         BUSY <= 1'b0;
         UNRESPONSIVE <= 1'b0;
      end
      else
      begin
         status_reg <= status_next;
         send_reg <= send_next;
         BUSY <= (state_next != LAT_ST_IDLE) && (state_next != LAT_ST_DEAD);
         UNRESPONSIVE <= (state_next == LAT_ST_DEAD);
      end
   end

   assign STATUS = status_reg;
   assign STATUS_VALID = send_reg;

   // ==========================================================================
   // checks
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SRST);

   chk_auth_fail_err: assert property ((state_reg == LAT_ST_AUTH) && CMAC_DONE && CMAC_FAIL |=>
      STATUS_VALID && (STATUS.code == LAT_STAT_TRUSTED) && (state_reg == LAT_ST_IDLE)) else $error("auth fail");
   chk_abnormal_auth_silent: assert property ((state_reg == LAT_ST_AUTH) && CMAC_DONE && !CMAC_FAIL &&
      (CMAC_VALUE == mac_reg) && TRUST_ABNORMAL |=> !STATUS_VALID && UNRESPONSIVE) else $error("abnormal auth");
   chk_erase_start: assert property ((state_reg == LAT_ST_AUTH) && (state_next == LAT_ST_ERASE) |=>
      ERASE_REQ && ERASE_MODE.force_erase && (ERASE_MODE.region == LAT_RGN_PROTECT)) else $error("erase start");
   chk_erase_fail: assert property ((state_reg == LAT_ST_ERASE) && !TRUST_ABNORMAL && FL_DONE && FL_ERR |=>
      STATUS_VALID && (STATUS.code == LAT_STAT_FLASH) && (STATUS.detail == $past(FL_STATUS))) else $error("erase err");
   chk_erase_silent: assert property ((state_reg == LAT_ST_ERASE) && TRUST_ABNORMAL |=>
      !STATUS_VALID ##1 (!STATUS_VALID && UNRESPONSIVE) [*3]) else $error("erase abnormal");
   chk_commit_silent: assert property ((state_reg == LAT_ST_COMMIT) && TRUST_ABNORMAL |=>
      !STATUS_VALID && UNRESPONSIVE) else $error("commit abnormal");
   chk_hw_dead: assert property ((state_reg == LAT_ST_CHECK) && !lc_valid(CUR_LIFECYCLE) |=>
      STATUS_VALID && (STATUS.code == LAT_STAT_HARDWARE) && UNRESPONSIVE) else $error("hw err");
   chk_ok_status: assert property (STATUS_VALID && (STATUS.code == LAT_STAT_OK) |->
      (STATUS.reply == LAT_REPLY_OK) && (UNRESPONSIVE == !is_al(cmd_reg.dst))) else $error("ok status");
   chk_unused_fields: assert property (STATUS_VALID && (STATUS.code != LAT_STAT_FLASH) |->
      (STATUS.detail == LAT_UNUSED) && (STATUS.adr == LAT_UNUSED)) else $error("unused fields");
   chk_err_reply_byte: assert property (STATUS_VALID && (STATUS.code != LAT_STAT_OK) |->
      STATUS.reply == LAT_REPLY_ERR) else $error("err reply byte");
   chk_bad_reply_code: assert property ((state_reg == LAT_ST_WAIT_RESP) && RESP_VALID && (RESP.reply != LAT_REPLY_OK)
      |=> STATUS_VALID && (STATUS.code == LAT_STAT_PACKET) && !CMAC_REQ) else $error("bad reply code");
   chk_dead_sticks: assert property (UNRESPONSIVE |=> UNRESPONSIVE && !BUSY) else $error("dead left");

   cov_level_ok: cover property (STATUS_VALID && (STATUS.code == LAT_STAT_OK) && !UNRESPONSIVE);
   cov_rtv_erase: cover property (ERASE_REQ && (ERASE_MODE.region == LAT_RGN_LAST));
   cov_flash_err: cover property (STATUS_VALID && (STATUS.code == LAT_STAT_FLASH));
   cov_protect: cover property (STATUS_VALID && (STATUS.code == LAT_STAT_PROTECT));
endmodule

// >>> tb/lat_far_model.sv
// far-side model: security engine, flash controller and state commit
`timescale 1ns/10ps
module lat_far_model
(
   // clock
   input wire logic clk,
   // requests from the sequencer
   input wire logic cmac_req,
   input wire logic erase_req,
   input wire logic [2:0] region,
   input wire logic commit_req,
   // behaviour chosen by the bench
   input wire logic [3:0] delay,
   input wire logic [127:0] mac,
   input wire logic mac_fail,
   input wire logic [2:0] err_region,
   input wire logic [31:0] err_status,
   input wire logic [31:0] err_addr,
   input wire logic err_disclosed,
   input wire logic want_cerr,
   input wire logic want_ctrust,
   // answers
   output logic cmac_done,
   output logic cmac_fail,
   output logic [127:0] cmac_value,
   output logic fl_done,
   output logic fl_err,
   output logic [31:0] fl_status,
   output logic [31:0] fl_addr,
   output logic fl_disclosed,
   output logic commit_done,
   output logic commit_err,
   output logic commit_err_trust
);
   logic [4:0] cnt = 5'h0;
   logic [1:0] kind = 2'h0;
   logic [2:0] rgn = 3'h0;
   logic fire;
   logic show;
   // ==========================================
   // one operation outstanding, answered after delay
   always @(posedge clk)
   begin
      if (cmac_req || erase_req || commit_req)
      begin
         cnt <= {1'b0, delay} + 5'h1;
         kind <= erase_req ? 2'h1 : (commit_req ? 2'h2 : 2'h0);
         rgn <= region;
      end
      else if (cnt != 5'h0)
         cnt <= cnt - 5'h1;
   end
   assign fire = (cnt == 5'h1);
   assign cmac_done = fire && kind == 2'h0;
   assign cmac_fail = cmac_done && mac_fail;
   assign cmac_value = cmac_done ? mac : ~mac;
   assign fl_done = fire && kind == 2'h1;
   assign fl_err = fl_done && rgn == err_region;
   assign commit_done = fire && kind == 2'h2;
   assign commit_err = commit_done && want_cerr;
   assign commit_err_trust = commit_done && want_ctrust;
   // flash report fields only meaningful with an error
   assign show = fl_err || commit_err;
   assign fl_status = show ? err_status : ~err_status;
   assign fl_addr = show ? err_addr : ~err_addr;
   assign fl_disclosed = show ? err_disclosed : ~err_disclosed;
endmodule

// >>> tb/lat_transition_test.sv
// self-checking bench for the transition sequencer
`timescale 1ns/10ps
module lat_transition_test;
   import lat_pkg::*;
   logic CORE_CLK = 1'b0;
   logic SRST = 1'b1;
   logic CMD_START = 1'b0;
   lat_cmd_type CMD = '0;
   logic [7:0] CUR_LIFECYCLE = 8'h02;
   logic [7:0] CUR_AUTH_LEVEL = 8'h10;
   logic PROT_LVL_BAD = 1'b0, LVL1_KEY_EN = 1'b1, LVL2_KEY_EN = 1'b1, RESP_VALID = 1'b0, TRUST_ABNORMAL = 1'b0;
   lat_resp_type RESP = '0;
   logic CMAC_DONE, CMAC_FAIL, CMAC_REQ, CMAC_KEY_LVL2, ERASE_REQ, FL_DONE, FL_ERR, FL_DISCLOSED;
   logic COMMIT_REQ, COMMIT_DONE, COMMIT_ERR, COMMIT_ERR_TRUST, STATUS_VALID, BUSY, UNRESPONSIVE;
   logic [127:0] CMAC_VALUE;
   logic [31:0] FL_STATUS, FL_ADDR;
   logic [7:0] COMMIT_DST;
   lat_erase_type ERASE_MODE;
   lat_status_type STATUS, last_st;
   logic [3:0] delay = 4'h0;
   logic [127:0] mac = '0;
   logic mac_fail = 1'b0, disc = 1'b0, c_err = 1'b0, c_trust = 1'b0, flip = 1'b0;
   logic [2:0] err_rgn = 3'h7;
   logic [31:0] e_code = '0, e_adr = '0;
   logic [7:0] p_reply = 8'h30;
   logic [7:0] last_dst = '0;
   logic [5:0] modes [$];
   // src dst challenge {key1,key2,bad} lifecycle status
   logic [47:0] tbl [8] = '{48'h11_12_00_06_02_c5, 48'h10_11_00_06_03_c5, 48'h10_12_00_04_02_c6,
      48'h02_04_00_04_02_c6, 48'h10_11_00_02_02_c6, 48'h10_11_01_06_02_c5, 48'h10_11_00_07_02_c9,
      48'h10_11_01_02_02_c6};
   int seed = 32'h3abb;
   int miscompares = 0, comparisons = 0, n_status = 0, n_before = 0, cycles = 0;
   lat_transition i_lat_transition (.CORE_CLK(CORE_CLK), .SRST(SRST), .CMD_START(CMD_START), .CMD(CMD),
      .CUR_LIFECYCLE(CUR_LIFECYCLE), .CUR_AUTH_LEVEL(CUR_AUTH_LEVEL), .PROT_LVL_BAD(PROT_LVL_BAD),
      .LVL1_KEY_EN(LVL1_KEY_EN), .LVL2_KEY_EN(LVL2_KEY_EN), .RESP_VALID(RESP_VALID), .RESP(RESP),
      .TRUST_ABNORMAL(TRUST_ABNORMAL), .CMAC_DONE(CMAC_DONE), .CMAC_FAIL(CMAC_FAIL), .CMAC_VALUE(CMAC_VALUE),
      .CMAC_REQ(CMAC_REQ), .CMAC_KEY_LVL2(CMAC_KEY_LVL2), .ERASE_REQ(ERASE_REQ), .ERASE_MODE(ERASE_MODE),
      .FL_DONE(FL_DONE), .FL_ERR(FL_ERR), .FL_STATUS(FL_STATUS), .FL_ADDR(FL_ADDR), .FL_DISCLOSED(FL_DISCLOSED),
      .COMMIT_REQ(COMMIT_REQ), .COMMIT_DST(COMMIT_DST), .COMMIT_DONE(COMMIT_DONE), .COMMIT_ERR(COMMIT_ERR),
      .COMMIT_ERR_TRUST(COMMIT_ERR_TRUST), .STATUS_VALID(STATUS_VALID), .STATUS(STATUS), .BUSY(BUSY),
      .UNRESPONSIVE(UNRESPONSIVE));
   lat_far_model i_lat_far_model (.clk(CORE_CLK), .cmac_req(CMAC_REQ), .erase_req(ERASE_REQ),
      .region(ERASE_MODE.region), .commit_req(COMMIT_REQ), .delay(delay), .mac(mac), .mac_fail(mac_fail),
      .err_region(err_rgn), .err_status(e_code), .err_addr(e_adr), .err_disclosed(disc), .want_cerr(c_err),
      .want_ctrust(c_trust), .cmac_done(CMAC_DONE), .cmac_fail(CMAC_FAIL), .cmac_value(CMAC_VALUE),
      .fl_done(FL_DONE), .fl_err(FL_ERR), .fl_status(FL_STATUS), .fl_addr(FL_ADDR), .fl_disclosed(FL_DISCLOSED),
      .commit_done(COMMIT_DONE), .commit_err(COMMIT_ERR), .commit_err_trust(COMMIT_ERR_TRUST));
   initial
   forever #20 CORE_CLK = ~CORE_CLK;
   // ==========================================
   // monitor and timeout
   always @(posedge CORE_CLK)
   begin
      cycles++;
      if (STATUS_VALID === 1'b1)
      begin
         n_status++;
         last_st = STATUS;
      end
      if (ERASE_REQ === 1'b1)
         modes.push_back(ERASE_MODE);
      if (COMMIT_REQ === 1'b1)
         last_dst = COMMIT_DST;
      if (cycles == 20000)
      begin
         miscompares++;
         close_out;
      end
   end
   // ==========================================
   // expectations and compares
   function automatic lat_status_type exp_pkt(input logic [7:0] code);
      exp_pkt = '{(code == LAT_STAT_OK) ? LAT_REPLY_OK : LAT_REPLY_ERR, code, LAT_UNUSED, LAT_UNUSED};
      if (code == LAT_STAT_FLASH)
         exp_pkt = '{LAT_REPLY_ERR, code, e_code, disc ? e_adr : LAT_UNUSED};
   endfunction
   function automatic lat_erase_type exp_mode(input int r);
      exp_mode = '{r[2:0], 1'b1, r == 1 || r == 3, r == 4};
   endfunction
   task automatic check(input logic [79:0] g, e);
      comparisons++;
      if (g !== e)
      begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic cmp_status(input lat_status_type g, e);
      check(g, e);
   endtask
   task automatic cmp_mode(input lat_erase_type g, e);
      check({74'h0, g}, {74'h0, e});
   endtask
   task automatic cmp_bit(input logic g, e);
      check({79'h0, g}, {79'h0, e});
   endtask
   task automatic cmp_dst(input logic [7:0] g, e);
      check({72'h0, g}, {72'h0, e});
   endtask
   task automatic close_out;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic do_reset;
      SRST = 1'b1;
      TRUST_ABNORMAL = 1'b0;
      CUR_LIFECYCLE = LAT_LC_MANUF;
      repeat (20) @(negedge CORE_CLK);
      SRST = 1'b0;
   endtask
   // one command: 1 trust after auth, 2 in erase, 3 in commit, 4 bad state after commit
   task automatic go(input logic [7:0] s, d, c, input int at, input logic [7:0] code, input logic silent, dead);
      int k;
      n_before = n_status;
      modes.delete();
      CMD_START = 1'b1;
      CMD = '{s, d, c};
      @(negedge CORE_CLK);
      CMD_START = 1'b0;
      if (BUSY === 1'b1)
      begin
         RESP_VALID = 1'b1;
         RESP = '{p_reply, {mac ^ {127'h0, flip}, {16{8'hff}}}};
         @(negedge CORE_CLK);
         RESP_VALID = 1'b0;
      end
      for (k = 0; k < 300 && BUSY === 1'b1; k++)
      begin
         if ((at == 1 && CMAC_REQ) || (at == 2 && ERASE_REQ) || (at == 3 && COMMIT_REQ))
            TRUST_ABNORMAL = 1'b1;
         if (at == 4 && COMMIT_REQ)
            CUR_LIFECYCLE = 8'h7e;
         @(negedge CORE_CLK);
      end
      repeat (2) @(negedge CORE_CLK);
      cmp_bit(k < 300, 1'b1);
      cmp_bit(n_status == n_before + (silent ? 0 : 1), 1'b1);
      if (!silent)
         cmp_status(last_st, exp_pkt(code));
      cmp_bit(UNRESPONSIVE, dead);
      cmp_bit(BUSY, 1'b0);
   endtask
   // ==========================================
   // main sequence
   initial
   begin
      logic [47:0] t;
      logic [7:0] d;
      do_reset;
      @(negedge CORE_CLK);
      cmp_status(STATUS, exp_pkt(LAT_STAT_OK));
      cmp_bit(UNRESPONSIVE | BUSY | CMAC_REQ | ERASE_REQ | COMMIT_REQ | STATUS_VALID, 1'b0);
      foreach (tbl[i])
      begin
         t = tbl[i];
         {LVL1_KEY_EN, LVL2_KEY_EN, PROT_LVL_BAD} = t[18:16];
         CUR_LIFECYCLE = t[15:8];
         go(t[47:40], t[39:32], t[31:24], 0, t[7:0], 1'b0, 1'b0);
      end
      {LVL1_KEY_EN, LVL2_KEY_EN, PROT_LVL_BAD} = 3'b110;
      CUR_LIFECYCLE = LAT_LC_MANUF;
      repeat (4)
      begin
         CUR_AUTH_LEVEL = ($random(seed) & 1) ? LAT_AL_ONE : LAT_AL_ZERO;
         d = (CUR_AUTH_LEVEL == LAT_AL_ZERO && ($random(seed) & 1)) ? LAT_AL_ONE : LAT_AL_TWO;
         delay = 4'($random(seed));
         mac = {$random(seed), $random(seed), $random(seed), $random(seed)};
         go(CUR_AUTH_LEVEL, d, LAT_CHAL_RANDOM, 0, LAT_STAT_OK, 1'b0, 1'b0);
         cmp_bit(CMAC_KEY_LVL2, d != LAT_AL_ONE);
         cmp_dst(last_dst, d);
         cmp_bit(modes.size() == 0, 1'b1);
      end
      CUR_AUTH_LEVEL = LAT_AL_ZERO;
      p_reply = 8'h28;
      go(LAT_AL_ZERO, LAT_AL_ONE, LAT_CHAL_RANDOM, 0, LAT_STAT_PACKET, 1'b0, 1'b0);
      p_reply = LAT_REPLY_OK;
      flip = 1'b1;
      go(LAT_AL_ZERO, LAT_AL_ONE, LAT_CHAL_RANDOM, 0, LAT_STAT_TRUSTED, 1'b0, 1'b0);
      flip = 1'b0;
      mac_fail = 1'b1;
      go(LAT_LC_MANUF, LAT_LC_RTV_REQ, LAT_CHAL_UID, 0, LAT_STAT_TRUSTED, 1'b0, 1'b0);
      cmp_bit(modes.size() == 0, 1'b1);
      mac_fail = 1'b0;
      go(LAT_AL_ZERO, LAT_AL_ONE, LAT_CHAL_RANDOM, 1, LAT_STAT_OK, 1'b1, 1'b1);
      do_reset;
      go(LAT_LC_MANUF, LAT_LC_RTV_REQ, LAT_CHAL_UID, 0, LAT_STAT_OK, 1'b0, 1'b1);
      cmp_bit(modes.size() == 6, 1'b1);
      cmp_bit(CMAC_KEY_LVL2, 1'b1);
      cmp_dst(last_dst, LAT_LC_RTV_REQ);
      foreach (modes[i])
         cmp_mode(modes[i], exp_mode(i));
      do_reset;
      repeat (3)
      begin
         err_rgn = 3'($unsigned($random(seed)) % 6);
         e_code = $random(seed);
         e_adr = $random(seed);
         disc = 1'($random(seed));
         go(LAT_LC_MANUF, LAT_LC_RTV_REQ, LAT_CHAL_RANDOM, 0, LAT_STAT_FLASH, 1'b0, 1'b0);
         cmp_bit(modes.size() == err_rgn + 1, 1'b1);
      end
      err_rgn = 3'h7;
      go(LAT_LC_MANUF, LAT_LC_RTV_REQ, LAT_CHAL_RANDOM, 2, LAT_STAT_OK, 1'b1, 1'b1);
      do_reset;
      go(LAT_AL_ZERO, LAT_AL_ONE, LAT_CHAL_RANDOM, 3, LAT_STAT_OK, 1'b1, 1'b1);
      do_reset;
      c_err = 1'b1;
      c_trust = 1'b1;
      go(LAT_AL_ZERO, LAT_AL_TWO, LAT_CHAL_RANDOM, 0, LAT_STAT_TRUSTED, 1'b0, 1'b0);
      c_trust = 1'b0;
      disc = 1'b0;
      go(LAT_AL_ZERO, LAT_AL_TWO, LAT_CHAL_RANDOM, 0, LAT_STAT_FLASH, 1'b0, 1'b0);
      c_err = 1'b0;
      go(LAT_AL_ZERO, LAT_AL_ONE, LAT_CHAL_RANDOM, 4, LAT_STAT_HARDWARE, 1'b0, 1'b1);
      close_out;
   end
endmodule
